// file: hdl/bcm_pkg.sv
/*
  constants, state encoding and register struct of the barrier close
  timer and mode logic.
  assumes a 10 MHz system clock; every pin and switch arrives asynchronously.
*/
// How it works
// (R1) hold-open delay comes from five switches; used after reversal and auto close
// (R2) switch pattern 00100 gives a four second hold before closing
// (R3) memory mode counts aux four vehicles; gate stays open until count runs out
// (R4) auto close shuts gate after the hold delay once the open, aux4 and close loop inputs are idle
// (R5) a timed auto close clears the stored vehicle count to zero
// (R6) forced up with both modes on closes again by the delay timer
// (R7) power-fail-open mode opens the gate fifteen seconds after mains loss
// (R8) after mains returns, stay open until close loop clears or timer expires
// (R9) obstruction while closing reverses to open, waits the delay, closes
// (R10) obstruction while opening stops travel, waits the delay, closes
// (R11) low battery during mains loss opens the gate regardless of the switch
// (R12) all delays count a fixed one second tick, restarted at each period start
package bcm_pkg;

  localparam int unsigned CLK_PERIOD_NS   = 100;
  localparam int unsigned TICK_PERIOD_MS  = 1000;
  localparam int unsigned TICK_CYCLES_1S  = TICK_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned PF_OPEN_DELAY_S = 15;

  localparam int PRESC_W = 24;
  localparam int HOLD_W  = 5;
  localparam int PF_W    = 4;
  localparam int CNT_W   = 4;

  // positions in the synchronised pin vector
  localparam int IN_OPEN   = 0;
  localparam int IN_AUX4   = 1;
  localparam int IN_CLOOP  = 2;
  localparam int IN_OBST   = 3;
  localparam int IN_OLIM   = 4;
  localparam int IN_CLIM   = 5;
  localparam int IN_PFAIL  = 6;
  localparam int IN_LOWBAT = 7;
  localparam int IN_MEM    = 8;
  localparam int IN_ACLOSE = 9;
  localparam int IN_FORCED = 10;
  localparam int IN_PFOPEN = 11;
  localparam int IN_DLY    = 12;
  localparam int IN_NUM    = IN_DLY + HOLD_W;

  localparam logic [PF_W-1:0]  PF_OPEN_TICKS = PF_W'(PF_OPEN_DELAY_S);
  localparam logic [CNT_W-1:0] CNT_MAX       = 4'hf;

  typedef enum logic [2:0] {
    ST_CLOSED     = 3'h0,
    ST_OPENING    = 3'h1,
    ST_OPEN       = 3'h3,
    ST_CLOSING    = 3'h2,
    ST_CLOSE_WAIT = 3'h6
  } bcm_state_t;

  typedef struct packed {
    logic [IN_NUM-1:0]  sync1;
    logic [IN_NUM-1:0]  sync2;
    logic [IN_NUM-1:0]  last;
    bcm_state_t         state;
    logic               hold_armed;
    logic               hold_auto;
    logic [HOLD_W-1:0]  hold_cnt;
    logic [PRESC_W-1:0] hold_presc;
    logic [PRESC_W-1:0] pf_presc;
    logic [PF_W-1:0]    pf_cnt;
    logic               pf_open;
    logic               pf_hold;
    logic [CNT_W-1:0]   vehicles;
    logic               motor_open;
    logic               motor_close;
  } bcm_regs_t;

endpackage

// file: hdl/bcm_gate_timer.sv
/*
  barrier gate mode and close timer: open and close commands to the motor
  drive from loops, access inputs, obstruction detector, limits and mains state.
  assumes all inputs are asynchronous levels from pins and switches.
*/
`timescale 1ns/1ns
module bcm_gate_timer
  import bcm_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYCLES_1S
) (
  input  wire logic              mclk,
  input  wire logic              nrst,
  input  wire logic              open_request,
  input  wire logic              aux4_request,
  input  wire logic              close_loop,
  input  wire logic              obstruction_reverse_detector,
  input  wire logic              open_limit,
  input  wire logic              close_limit,
  input  wire logic              power_fail,
  input  wire logic              low_battery,
  input  wire logic              memory_enable,
  input  wire logic              auto_close_enable,
  input  wire logic              forced_up_alarm_enable,
  input  wire logic              power_fail_open_enable,
  input  wire logic [HOLD_W-1:0] hold_delay_sw,
  output logic                   motor_open,
  output logic                   motor_close,
  output logic [CNT_W-1:0]       vehicle_count,
  output logic                   hold_active
);

  bcm_regs_t r;
  bcm_regs_t next_r;

  // switch pattern read as whole seconds: switch 3 alone is 4 s
  function automatic logic [HOLD_W-1:0] hold_reload(input logic [IN_NUM-1:0] v);
    hold_reload = v[IN_DLY +: HOLD_W]; // R1 R2
  endfunction

  logic [IN_NUM-1:0] s;
  logic              aux4_rise;
  logic              cloop_fall;
  logic              forced_up;
  logic              inputs_idle;
  logic              hold_tick;
  logic              pf_tick;
  logic              hold_done;
  logic              open_cause;

  assign s           = r.sync2;
  assign aux4_rise   = s[IN_AUX4] & ~r.last[IN_AUX4];
  assign cloop_fall  = ~s[IN_CLOOP] & r.last[IN_CLOOP];
  assign forced_up   = ~s[IN_CLIM] & r.last[IN_CLIM];
  assign inputs_idle = ~s[IN_OPEN] & ~s[IN_AUX4] & ~s[IN_CLOOP];
  assign hold_tick   = r.hold_presc == PRESC_W'(TICK_CYCLES - 1); // R12
  assign pf_tick     = r.pf_presc == PRESC_W'(TICK_CYCLES - 1); // R12
  assign hold_done   = r.hold_armed & (r.hold_cnt == '0);
  assign open_cause  = s[IN_OPEN] | aux4_rise | r.pf_open;

  always_comb begin
    next_r       = r;
    next_r.sync1 = {hold_delay_sw, power_fail_open_enable, forced_up_alarm_enable,
                    auto_close_enable, memory_enable, low_battery, power_fail,
                    close_limit, open_limit, obstruction_reverse_detector,
                    close_loop, aux4_request, open_request};
    next_r.sync2 = r.sync1;
    next_r.last  = r.sync2;

    // hold timer, one second ticks from its own restartable prescaler
    if (r.hold_armed && r.hold_cnt != '0) begin
      next_r.hold_presc = hold_tick ? '0 : r.hold_presc + PRESC_W'(1);
      if (hold_tick) begin
        next_r.hold_cnt = r.hold_cnt - HOLD_W'(1);
      end
    end

    // mains loss timer
    if (s[IN_PFAIL]) begin
      next_r.pf_hold = 1'b1; // R8
      if (s[IN_LOWBAT]) begin
        next_r.pf_open = 1'b1; // R11
      end
      if (s[IN_PFOPEN] && !r.pf_open) begin
        next_r.pf_presc = pf_tick ? '0 : r.pf_presc + PRESC_W'(1);
        if (pf_tick) begin
          next_r.pf_cnt = r.pf_cnt + PF_W'(1);
        end
        if (r.pf_cnt == PF_OPEN_TICKS) begin
          next_r.pf_open = 1'b1; // R7
        end
      end
    end else begin
      next_r.pf_presc = '0;
      next_r.pf_cnt   = '0;
      next_r.pf_open  = 1'b0;
    end

    // vehicle memory; an arrival and a departure together cancel
    if (s[IN_MEM]) begin
      if (aux4_rise && !cloop_fall && r.vehicles != CNT_MAX) begin
        next_r.vehicles = r.vehicles + CNT_W'(1); // R3
      end else if (cloop_fall && !aux4_rise && r.vehicles != '0) begin
        next_r.vehicles = r.vehicles - CNT_W'(1); // R3
      end
    end else begin
      next_r.vehicles = '0;
    end

    case (r.state)
      ST_CLOSED: begin
        next_r.hold_armed = 1'b0;
        if (open_cause) begin
          next_r.state = ST_OPENING;
        end else if (forced_up && !r.motor_close) begin
          next_r.state = ST_OPEN;
          if (s[IN_FORCED] && s[IN_ACLOSE]) begin
            next_r.hold_armed = 1'b1; // R6
            next_r.hold_cnt   = hold_reload(s);
            next_r.hold_presc = '0; // R12
          end
        end
      end
      ST_OPENING: begin
        if (s[IN_OBST]) begin
          next_r.state      = ST_OPEN; // R10
          next_r.hold_armed = 1'b1;
          next_r.hold_auto  = 1'b0;
          next_r.hold_cnt   = hold_reload(s);
          next_r.hold_presc = '0; // R12
        end else if (s[IN_OLIM]) begin
          next_r.state = ST_OPEN;
        end
      end
      ST_OPEN: begin
        if (s[IN_ACLOSE] && !inputs_idle && (!r.hold_armed || r.hold_auto)) begin
          next_r.hold_armed = 1'b0; // R4
        end else if (s[IN_ACLOSE] && inputs_idle && !r.hold_armed) begin
          next_r.hold_armed = 1'b1; // R4
          next_r.hold_auto  = 1'b1;
          next_r.hold_cnt   = hold_reload(s);
          next_r.hold_presc = '0; // R12
        end
        if (s[IN_PFAIL] || r.pf_open) begin
          next_r.state = ST_OPEN; // R7 R8
        end else if (hold_done) begin
          next_r.state = ST_CLOSING; // R4 R9 R10
          if (r.hold_auto) begin
            next_r.vehicles = '0; // R5
          end
        end else if (cloop_fall && (!s[IN_MEM] || r.vehicles <= CNT_W'(1))) begin
          next_r.state = ST_CLOSING; // R3 R8
        end
        if (next_r.state == ST_CLOSING) begin
          next_r.hold_armed = 1'b0;
          next_r.hold_auto  = 1'b0;
          next_r.pf_hold    = s[IN_PFAIL]; // R8
        end
      end
      ST_CLOSING: begin
        if (s[IN_OBST]) begin
          next_r.state      = ST_OPENING; // R9
          next_r.hold_armed = 1'b0;
        end else if (open_cause) begin
          next_r.state = ST_OPENING;
        end else if (s[IN_CLOOP]) begin
          next_r.state = ST_CLOSE_WAIT;
        end else if (s[IN_CLIM]) begin
          next_r.state = ST_CLOSED;
        end
      end
      ST_CLOSE_WAIT: begin
        if (open_cause) begin
          next_r.state = ST_OPENING;
        end else if (!s[IN_CLOOP]) begin
          next_r.state = ST_CLOSING;
        end
      end
      default: begin
        next_r.state = ST_CLOSED;
      end
    endcase

    // reversal arms the hold once fully open again
    if (r.state == ST_CLOSING && s[IN_OBST]) begin
      next_r.hold_auto = 1'b0;
    end
    if (r.state == ST_OPENING && next_r.state == ST_OPEN && r.motor_close) begin
      next_r.hold_armed = 1'b1;
    end

    next_r.motor_open  = next_r.state == ST_OPENING;
    next_r.motor_close = next_r.state == ST_CLOSING;
  end

  // obstruction reversal: remember it across the opening travel
  logic rev_pending;
  logic next_rev_pending;

  always_comb begin
    next_rev_pending = rev_pending;
    if (r.state == ST_CLOSING && s[IN_OBST]) begin
      next_rev_pending = 1'b1; // R9
    end else if (r.state == ST_OPENING && next_r.state == ST_OPEN) begin
      next_rev_pending = 1'b0;
    end else if (r.state != ST_OPENING) begin
      next_rev_pending = 1'b0;
    end
  end

  bcm_regs_t next_q;

  always_comb begin
    next_q = next_r;
    if (rev_pending && r.state == ST_OPENING && next_r.state == ST_OPEN) begin
      next_q.hold_armed = 1'b1; // R9
      next_q.hold_auto  = 1'b0;
      next_q.hold_cnt   = hold_reload(s);
      next_q.hold_presc = '0; // R12
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      r           <= '0;
      rev_pending <= 1'b0;
    end else begin
      r           <= next_q;
      rev_pending <= next_rev_pending;
    end
  end

  assign motor_open    = r.motor_open;
  assign motor_close   = r.motor_close;
  assign vehicle_count = r.vehicles;
  assign hold_active   = r.hold_armed;

endmodule

// file: sim/bcm_gate_timer_chk.sv
/* port checker of the barrier close timer, bound into it by the bench.
   assumes TICK_CYCLES is handed on from the design instance. */
`timescale 1ns/1ns
module bcm_gate_chk #(
  parameter int unsigned TICK_CYCLES = 10
) (
  input wire logic       mclk,
  input wire logic       nrst,
  input wire logic       open_request,
  input wire logic       aux4_request,
  input wire logic       close_loop,
  input wire logic       obstruction_reverse_detector,
  input wire logic       open_limit,
  input wire logic       close_limit,
  input wire logic       power_fail,
  input wire logic       low_battery,
  input wire logic       memory_enable,
  input wire logic       auto_close_enable,
  input wire logic       forced_up_alarm_enable,
  input wire logic       power_fail_open_enable,
  input wire logic [4:0] hold_delay_sw,
  input wire logic       motor_open,
  input wire logic       motor_close,
  input wire logic [3:0] vehicle_count,
  input wire logic       hold_active
);
  int run;
  int pfr;
  // length of the current hold and of the current power-fail wait
  always_ff @(posedge mclk) begin
    run <= hold_active ? run + 1 : 0;
    pfr <= (power_fail && power_fail_open_enable && !low_battery) ? pfr + 1 : 0;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  a_motor_exclusive: assert property (!(motor_open && motor_close))
    else $error("open and close driven together");
  a_close_reverse: assert property ($rose(obstruction_reverse_detector) && motor_close
    |-> ##[1:5] motor_open) else $error("no reversal on obstruction");
  a_open_stop: assert property ($rose(obstruction_reverse_detector) && motor_open
    && !open_limit |-> ##[1:5] !motor_open ##[0:2] hold_active) else $error("no stop");
  // a hold dropped by open or aux4 seen three edges back, or close loop four back, is a restart, not an expiry
  a_hold_length: assert property ($fell(hold_active) && !power_fail && !open_request
    && !aux4_request && !close_loop && !$past(open_request, 3)
    && !$past(aux4_request, 3) && !$past(close_loop, 4)
    |-> run + 1 >= int'(hold_delay_sw) * TICK_CYCLES)
    else $error("hold ended early");
  a_expiry_close: assert property ($fell(hold_active) && !power_fail && !close_loop
    && !obstruction_reverse_detector && !$past(open_request, 3)
    && !$past(aux4_request, 3) && !$past(close_loop, 4)
    |-> ##[0:2] motor_close) else $error("no close");
  a_count_step: assert property (vehicle_count != $past(vehicle_count)
    |-> vehicle_count == $past(vehicle_count) + 4'h1 || vehicle_count == 4'h0
    || vehicle_count + 4'h1 == $past(vehicle_count)) else $error("count jump");
  a_timed_clear: assert property ($fell(hold_active) && auto_close_enable
    && memory_enable && !close_loop && !power_fail && !$past(open_request, 3)
    && !$past(aux4_request, 3) && !$past(close_loop, 4)
    |-> ##[0:3] vehicle_count == 4'h0)
    else $error("count kept");
  a_pf_early: assert property ($rose(motor_open) && pfr > 0 && !open_request
    && !aux4_request |-> pfr >= 15 * TICK_CYCLES) else $error("early open");
  a_pf_late: assert property (pfr == 17 * TICK_CYCLES |-> motor_open || open_limit)
    else $error("late open");
  a_lowbat_open: assert property ($rose(low_battery) && power_fail && close_limit
    |-> ##[1:6] motor_open) else $error("no open on low battery");
endmodule

// file: sim/bcm_arm_model.sv
/* arm and motor drive: limit switches follow the motor commands.
   assumes one travel step a clock; push_up lifts the arm by hand. */
`timescale 1ns/1ns
module bcm_arm_model #(
  parameter int TRAVEL = 12
) (
  input  wire logic mclk,
  input  wire logic nrst,
  input  wire logic motor_open,
  input  wire logic motor_close,
  input  wire logic push_up,
  output logic      open_limit,
  output logic      close_limit
);
  int pos;
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      pos <= 0;
    end else if ((motor_open || push_up) && pos < TRAVEL) begin
      pos <= pos + 1;
    end else if (motor_close && pos > 0) begin
      pos <= pos - 1;
    end
  end
  assign open_limit  = (pos == TRAVEL);
  assign close_limit = (pos == 0);
endmodule

// file: sim/test_barrier_close_timer_modes.sv
/* self-checking bench of the barrier close timer with an arm model.
   assumes a short tick of TICK cycles a second. */
`timescale 1ns/1ns
module test_barrier_close_timer_modes;
  localparam int TICK = 10;
  `define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_mismatch++; \
    $display("MISMATCH %0t got %h exp %h", $time, a, b); end end
  logic       mclk = 1'b0;
  logic       nrst = 1'b0;
  logic [4:0] req = 5'h00;
  logic [5:0] md = 6'h00;
  logic [4:0] hold_delay_sw = 5'h04;
  int         n_mismatch = 0;
  int         check_count = 0;
  wire        motor_open, motor_close, hold_active, open_limit, close_limit;
  wire  [3:0] vehicle_count;
  wire        open_request = req[0], aux4_request = req[1], close_loop = req[2];
  wire        obstruction_reverse_detector = req[3], push_up = req[4];
  wire        memory_enable = md[0], auto_close_enable = md[1];
  wire        forced_up_alarm_enable = md[2], power_fail_open_enable = md[3];
  wire        power_fail = md[4], low_battery = md[5];
  wire  [4:0] mon = {hold_active, close_limit, open_limit, motor_close, motor_open};
  always #50 mclk = ~mclk;
  bcm_gate_timer #(.TICK_CYCLES(TICK)) dut (.*);
  bcm_arm_model arm (.*);
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic pulse(input int s, input int len);
    @(posedge mclk) req[s] <= 1'b1;
    repeat (len) @(posedge mclk);
    req[s] <= 1'b0;
    cyc(len);
  endtask
  task automatic wait_on(input int s, output int t);
    t = 0;
    while (mon[s] !== 1'b1 && t < 500) begin
      cyc(1);
      t++;
    end
  endtask
  task automatic hold_chk;
    int t;
    int e;
    e = hold_delay_sw * TICK;
    wait_on(4, t);
    wait_on(1, t);
    `CHK(t inside {[e - 1:e + 4]}, 1'b1)
  endtask
  task automatic shut(input string s);
    int t;
    wait_on(3, t);
    cyc(6);
    $display("done %s", s);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge mclk);
    n_mismatch++;
    conclude();
  end
  initial begin
    int t;
    int n;
    int dl[4] = '{4, 0, 31, 4};
    void'($urandom(34143));
    dl[3] = $urandom_range(1, 30);
    repeat (16) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk) md <= 6'h02;
    foreach (dl[i]) begin
      @(posedge mclk) hold_delay_sw <= 5'(dl[i]);
      pulse(0, 4);
      hold_chk();
      shut("hold delay");
    end
    @(posedge mclk) md <= 6'h01;
    pulse(0, 4);
    wait_on(2, t);
    n = $urandom_range(2, 5);
    repeat (n) pulse(1, 3);
    `CHK(vehicle_count, 4'(n))
    for (int k = n - 1; k >= 0; k--) begin
      pulse(2, 3);
      cyc(4);
      `CHK({motor_close, vehicle_count}, {k == 0, 4'(k)})
    end
    shut("memory");
    @(posedge mclk) {md, hold_delay_sw} <= {6'h03, 5'h04};
    pulse(0, 4);
    repeat (2) pulse(1, 2);
    `CHK(vehicle_count, 4'h2)
    wait_on(1, t);
    cyc(3);
    `CHK(vehicle_count, 4'h0)
    shut("timed clear");
    @(posedge mclk) md <= 6'h00;
    pulse(0, 4);
    wait_on(2, t);
    pulse(2, 2);
    wait_on(1, t);
    cyc(3);
    pulse(3, 1);
    wait_on(0, t);
    `CHK(t < 6, 1'b1)
    hold_chk();
    shut("reverse");
    pulse(0, 1);
    wait_on(0, t);
    pulse(3, 1);
    wait_on(4, t);
    `CHK({t < 6, open_limit}, 2'h2)
    hold_chk();
    shut("stop");
    @(posedge mclk) md <= 6'h06;
    pulse(4, 1);
    hold_chk();
    shut("forced up");
    @(posedge mclk) md <= 6'h18;
    wait_on(0, t);
    `CHK(t inside {[15 * TICK:17 * TICK]}, 1'b1)
    wait_on(2, t);
    @(posedge mclk) md <= 6'h08;
    cyc(60);
    `CHK(motor_close, 1'b0)
    pulse(2, 2);
    wait_on(1, t);
    `CHK(t < 6, 1'b1)
    shut("power fail");
    @(posedge mclk) md <= 6'h30;
    wait_on(0, t);
    `CHK(t < 6, 1'b1)
    wait_on(2, t);
    @(posedge mclk) md <= 6'h00;
    pulse(2, 2);
    shut("low battery");
    conclude();
  end
endmodule
bind bcm_gate_timer bcm_gate_chk #(.TICK_CYCLES(TICK_CYCLES)) chk (.*);
